// ==== core/cise_pkg.sv ====
package cise_pkg;
   localparam int DATA_W   = 8;
   localparam int FADDR_W  = 7;
   localparam int PC_W     = 15;
   localparam int WORD_W   = 14;
   localparam int JUMP_W   = 11;

   // opcode patterns on the 14-bit instruction word
   localparam logic [13:0] OPC_CLEAR_ACC   = 14'h0103;
   localparam logic [13:0] MASK_CLEAR_ACC  = 14'h3FFF;
   localparam logic [13:0] OPC_SUB_SKIP    = 14'h0B00;
   localparam logic [13:0] OPC_ADD_SKIP    = 14'h0F00;
   localparam logic [13:0] OPC_ADD_FILE    = 14'h0A00;
   localparam logic [13:0] OPC_OR_FILE     = 14'h0400;
   localparam logic [13:0] MASK_FILE_OP    = 14'h3F00;
   localparam logic [13:0] OPC_OR_LIT      = 14'h3800;
   localparam logic [13:0] MASK_OR_LIT     = 14'h3F00;
   localparam logic [13:0] OPC_JUMP        = 14'h2800;
   localparam logic [13:0] MASK_JUMP       = 14'h3800;

   localparam int DEST_BIT = 7;
   localparam logic [7:0]  RESET_ACC   = 8'h00;
   localparam logic [7:0]  CLEAR_VALUE = 8'h00;
   localparam logic [7:0]  ONE         = 8'h01;
   localparam logic [14:0] RESET_PC    = 15'h0000;

   typedef enum logic [1:0] {
      CISE_RUN,
      CISE_FLUSH
   } cise_state_t;
endpackage : cise_pkg

// ==== core/cise_alu.sv ====
`timescale 1ns/1ns
`default_nettype none
module cise_alu
   import cise_pkg::*;
(
   input  wire logic [2:0] op,
   input  wire logic [7:0] acc,
   input  wire logic [7:0] fval,
   input  wire logic [7:0] lit,
   output logic      [7:0] result,
   output logic            is_null
);
   // op: 0 clear, 1 sub one, 2 add one, 3 or literal, 4 or file
   always_comb begin
      case (op)
         3'h0:    result = CLEAR_VALUE;
         3'h1:    result = fval - ONE;
         3'h2:    result = fval + ONE;
         3'h3:    result = acc | lit;
         3'h4:    result = acc | fval;
         default: result = acc;
      endcase
      is_null = (result == CLEAR_VALUE);
   end
endmodule // cise_alu
`default_nettype wire

// ==== core/cise_core.sv ====
`timescale 1ns/1ns
`default_nettype none
module cise_core
   import cise_pkg::*;
(
   input  wire logic        REF_CLK,
   input  wire logic        RESET_N,
   input  wire logic        INSTR_VALID,
   input  wire logic [13:0] INSTR,
   input  wire logic [7:0]  FILE_RDATA,
   input  wire logic [6:0]  PAGE_LATCH,
   output logic      [6:0]  FILE_ADDR,
   output logic      [7:0]  FILE_WDATA,
   output logic             FILE_WE,
   output logic      [7:0]  ACC,
   output logic             NULL_FLAG,
   output logic      [14:0] PC,
   output logic             PC_LOAD,
   output logic             NOP_CYCLE,
   output logic             UNKNOWN_OP
);
   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   logic       is_clear;
   logic       is_sub_skip;
   logic       is_add_skip;
   logic       is_add_file;
   logic       is_or_lit;
   logic       is_or_file;
   logic       is_jump;
   logic       dest_file;
   logic [2:0] alu_op;
   logic [7:0] alu_result;
   logic       alu_null;

   always_comb begin
      is_clear    = (INSTR & MASK_CLEAR_ACC) == OPC_CLEAR_ACC;
      is_sub_skip = (INSTR & MASK_FILE_OP) == OPC_SUB_SKIP;
      is_add_skip = (INSTR & MASK_FILE_OP) == OPC_ADD_SKIP;
      is_add_file = (INSTR & MASK_FILE_OP) == OPC_ADD_FILE;
      is_or_file  = (INSTR & MASK_FILE_OP) == OPC_OR_FILE;
      is_or_lit   = (INSTR & MASK_OR_LIT) == OPC_OR_LIT;
      is_jump     = (INSTR & MASK_JUMP) == OPC_JUMP;
      dest_file   = INSTR[DEST_BIT];
      if (is_clear) begin
         alu_op = 3'h0;
      end else if (is_sub_skip) begin
         alu_op = 3'h1;
      end else if (is_add_skip || is_add_file) begin
         alu_op = 3'h2;
      end else if (is_or_lit) begin
         alu_op = 3'h3;
      end else if (is_or_file) begin
         alu_op = 3'h4;
      end else begin
         alu_op = 3'h7;
      end
   end

   // ---------------------------------------------------------------
   // arithmetic
   // ---------------------------------------------------------------
   cise_alu u_alu (
      .op      (alu_op),
      .acc     (ACC),
      .fval    (FILE_RDATA),
      .lit     (INSTR[7:0]),
      .result  (alu_result),
      .is_null (alu_null)
   );

   // ---------------------------------------------------------------
   // sequencing: flush slot, program counter, cycle pulses
   // ---------------------------------------------------------------
   // the file address leaves as a registered copy of the address field; the
   // write is registered as well, so address and data reach the file together
   cise_state_t state;
   cise_state_t next_state;
   logic        take;
   logic        is_known;
   logic [14:0] next_pc;
   logic        next_pc_load;
   logic        next_nop_cycle;
   logic        next_unknown;

   always_comb begin
      is_known       = is_clear || is_sub_skip || is_add_skip || is_add_file ||
                       is_or_file || is_or_lit || is_jump;
      take           = 1'b0;
      next_state     = state;
      next_pc        = PC;
      next_pc_load   = 1'b0;
      next_nop_cycle = 1'b0;
      next_unknown   = 1'b0;

      case (state)
         CISE_FLUSH: begin
            // the discarded slot runs as a nop; with no word on offer it waits,
            // so a late word after a jump or a skip is still thrown away
            next_nop_cycle = 1'b1;
            if (INSTR_VALID) begin
               next_state = CISE_RUN;
            end
         end
         CISE_RUN: begin
            take = INSTR_VALID;
            if (INSTR_VALID) begin
               if (is_jump) begin
                  next_pc      = {PAGE_LATCH[6:3], INSTR[10:0]};
                  next_pc_load = 1'b1;
                  next_state   = CISE_FLUSH;
               end else if ((is_sub_skip || is_add_skip) && alu_null) begin
                  next_state = CISE_FLUSH;
               end else if (!is_known) begin
                  // outside the subset: no effect, only flagged to the surrounding core
                  next_unknown = 1'b1;
               end
            end
         end
         default: begin
            next_state = CISE_RUN;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // sequencing registers
   // ---------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (!RESET_N) begin
         state      <= CISE_RUN;
         PC         <= RESET_PC;
         PC_LOAD    <= 1'b0;
         NOP_CYCLE  <= 1'b0;
         UNKNOWN_OP <= 1'b0;
      end else begin
         state      <= next_state;
         PC         <= next_pc;
         PC_LOAD    <= next_pc_load;
         NOP_CYCLE  <= next_nop_cycle;
         UNKNOWN_OP <= next_unknown;
      end
   end

   // ---------------------------------------------------------------
   // data path: accumulator, null flag, file write-back
   // ---------------------------------------------------------------
   logic [7:0]  next_acc;
   logic        next_null_flag;
   logic [6:0]  next_file_addr;
   logic [7:0]  next_file_wdata;
   logic        next_file_we;

   always_comb begin
      next_acc        = ACC;
      next_null_flag  = NULL_FLAG;
      next_file_addr  = INSTR[6:0];
      next_file_wdata = FILE_WDATA;
      next_file_we    = 1'b0;

      // a discarded word leaves every register but FILE_ADDR as it stands; FILE_WE drops low
      if (take) begin
         if (is_clear) begin
            next_acc       = alu_result;
            next_null_flag = 1'b1;
         end else if (is_sub_skip || is_add_skip) begin
            // no flag change on the skip forms
            if (dest_file) begin
               next_file_we    = 1'b1;
               next_file_wdata = alu_result;
            end else begin
               next_acc = alu_result;
            end
         end else if (is_add_file || is_or_file) begin
            if (dest_file) begin
               next_file_we    = 1'b1;
               next_file_wdata = alu_result;
            end else begin
               next_acc = alu_result;
            end
            next_null_flag = alu_null;
         end else if (is_or_lit) begin
            next_acc       = alu_result;
            next_null_flag = alu_null;
         end
      end
   end

   // ---------------------------------------------------------------
   // data registers
   // ---------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (!RESET_N) begin
         ACC        <= RESET_ACC;
         NULL_FLAG  <= 1'b0;
         FILE_ADDR  <= 7'h00;
         FILE_WDATA <= 8'h00;
         FILE_WE    <= 1'b0;
      end else begin
         ACC        <= next_acc;
         NULL_FLAG  <= next_null_flag;
         FILE_ADDR  <= next_file_addr;
         FILE_WDATA <= next_file_wdata;
         FILE_WE    <= next_file_we;
      end
   end
endmodule // cise_core
`default_nettype wire

// ==== tb/cise_core_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module cise_core_asserts
   import cise_pkg::*;
(
   input wire logic        REF_CLK,
   input wire logic        RESET_N,
   input wire logic        INSTR_VALID,
   input wire logic [13:0] INSTR,
   input wire logic [7:0]  FILE_RDATA,
   input wire logic [6:0]  PAGE_LATCH,
   input wire logic [7:0]  FILE_WDATA,
   input wire logic        FILE_WE,
   input wire logic [7:0]  ACC,
   input wire logic        NULL_FLAG,
   input wire logic [14:0] PC,
   input wire logic        PC_LOAD,
   input wire logic        NOP_CYCLE
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);
   logic [7:0]  acc_q;
   logic [7:0]  fr_q;
   logic [13:0] in_q;
   logic [6:0]  pl_q;
   wire         v   = INSTR_VALID;
   wire  [13:0] fop = INSTR & MASK_FILE_OP;
   always_ff @(posedge REF_CLK) begin
      acc_q <= ACC;
      fr_q  <= FILE_RDATA;
      in_q  <= INSTR;
      pl_q  <= PAGE_LATCH;
   end
   // ----------------
   // checks
   // ----------------
   // a discarded slot (nop cycle) excuses every effect check but a_skip_flag
   a_clear_acc: assert property (v && INSTR == OPC_CLEAR_ACC |=> NOP_CYCLE ||
      (ACC == 8'h00 && NULL_FLAG)) else $error("clear wrong");
   a_sub_dest: assert property (v && fop == OPC_SUB_SKIP && !INSTR[7] |=>
      NOP_CYCLE || ACC == fr_q - 8'h01) else $error("decrement wrong");
   a_skip_nop: assert property (v && (fop == OPC_SUB_SKIP && FILE_RDATA == 8'h01 ||
      fop == OPC_ADD_SKIP && FILE_RDATA == 8'hFF) ##1 !NOP_CYCLE |=> NOP_CYCLE)
      else $error("skip missing");
   a_skip_keep: assert property (v && fop == OPC_SUB_SKIP && FILE_RDATA != 8'h01 ##1
      !NOP_CYCLE |=> !NOP_CYCLE) else $error("skip without null result");
   a_skip_flag: assert property (v && (fop == OPC_SUB_SKIP || fop == OPC_ADD_SKIP) |=>
      $stable(NULL_FLAG)) else $error("skip moved flag");
   a_add_file: assert property (v && fop == OPC_ADD_FILE && INSTR[7] |=> NOP_CYCLE ||
      FILE_WE && FILE_WDATA == fr_q + 8'h01 && NULL_FLAG == (FILE_WDATA == 8'h00))
      else $error("increment wrong");
   a_jump_target: assert property (v && (INSTR & MASK_JUMP) == OPC_JUMP |=> NOP_CYCLE ||
      PC_LOAD && PC == {pl_q[6:3], in_q[10:0]}) else $error("jump target wrong");
   a_jump_flush: assert property (PC_LOAD |=> NOP_CYCLE)
      else $error("jump not flushed");
   a_or_lit: assert property (v && (INSTR & MASK_OR_LIT) == OPC_OR_LIT |=> NOP_CYCLE ||
      ACC == (acc_q | in_q[7:0]) && NULL_FLAG == (ACC == 8'h00)) else $error("or literal wrong");
   a_or_file: assert property (v && fop == OPC_OR_FILE && INSTR[7] |=> NOP_CYCLE ||
      FILE_WE && FILE_WDATA == (acc_q | fr_q)) else $error("or file wrong");
   c_jump: cover property (PC_LOAD);
   c_nop: cover property (NOP_CYCLE);
   c_write: cover property (FILE_WE && FILE_WDATA == 8'h00);
endmodule // cise_core_asserts
`default_nettype wire

// ==== tb/cise_core_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module cise_core_tb
   import cise_pkg::*;
;
   logic        REF_CLK = 1'b0;
   logic        RESET_N = 1'b0;
   logic        INSTR_VALID = 1'b0;
   logic [13:0] INSTR = 14'h0000;
   logic [7:0]  FILE_RDATA = 8'h00;
   logic [6:0]  PAGE_LATCH = 7'h00;
   wire  [6:0]  FILE_ADDR;
   wire  [7:0]  FILE_WDATA;
   wire         FILE_WE;
   wire  [7:0]  ACC;
   wire         NULL_FLAG;
   wire  [14:0] PC;
   wire         PC_LOAD;
   wire         NOP_CYCLE;
   wire         UNKNOWN_OP;
   int          n_errors = 0;
   int          total_checks = 0;
   int          cyc = 0;
   cise_core i_dut (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .INSTR_VALID(INSTR_VALID),
      .INSTR(INSTR), .FILE_RDATA(FILE_RDATA), .PAGE_LATCH(PAGE_LATCH), .FILE_ADDR(FILE_ADDR),
      .FILE_WDATA(FILE_WDATA), .FILE_WE(FILE_WE), .ACC(ACC), .NULL_FLAG(NULL_FLAG), .PC(PC),
      .PC_LOAD(PC_LOAD), .NOP_CYCLE(NOP_CYCLE), .UNKNOWN_OP(UNKNOWN_OP));
   initial forever #25 REF_CLK = ~REF_CLK;
   // ----------------
   // helpers
   // ----------------
   task close_out;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge REF_CLK) begin
      cyc++;
      if (cyc == 2000) begin
         n_errors++;
         close_out();
      end
   end
   task chk(input logic [16:0] seen, input logic [16:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t saw %h want %h", $time, seen, exp);
      end
   endtask
   // one idle cycle between words keeps every strobe edge distinct
   task issue(input logic [13:0] i, input logic [7:0] r);
      @(posedge REF_CLK);
      INSTR_VALID <= 1'b1;
      INSTR <= i;
      FILE_RDATA <= r;
      @(posedge REF_CLK);
      INSTR_VALID <= 1'b0;
      #1;
   endtask
   task t_or_clear;
      issue(OPC_OR_LIT | 14'h005A, 8'h00);
      chk({NULL_FLAG, ACC}, 9'h05A);
      issue(OPC_CLEAR_ACC, 8'hFF);
      chk({NULL_FLAG, ACC}, 9'h100);
      issue(14'h0102, 8'h00);
      chk({UNKNOWN_OP, NULL_FLAG, ACC}, 10'h300);
      issue(OPC_OR_LIT, 8'h00);
      chk(NULL_FLAG, 1'b1);
   endtask
   task t_sub_skip;
      issue(OPC_SUB_SKIP | 14'h0085, 8'h01);
      chk({NULL_FLAG, FILE_WE, FILE_ADDR, FILE_WDATA}, 17'h18500);
      issue(OPC_OR_LIT | 14'h000F, 8'h00);
      chk({NOP_CYCLE, ACC}, 9'h100);
      issue(OPC_SUB_SKIP | 14'h0005, 8'h10);
      chk({FILE_WE, ACC}, 9'h00F);
      issue(OPC_OR_LIT | 14'h0080, 8'h00);
      chk({NOP_CYCLE, ACC}, 9'h08F);
   endtask
   task t_add;
      issue(OPC_ADD_SKIP | 14'h0003, 8'hFF);
      chk({NULL_FLAG, ACC}, 9'h000);
      issue(OPC_OR_LIT | 14'h0001, 8'h00);
      chk({NOP_CYCLE, ACC}, 9'h100);
      issue(OPC_ADD_FILE | 14'h00FF, 8'hFF);
      chk({NULL_FLAG, FILE_WE, FILE_ADDR, FILE_WDATA}, 17'h1FF00);
      issue(OPC_ADD_FILE | 14'h0001, 8'h41);
      chk({NULL_FLAG, ACC}, 9'h042);
   endtask
   task t_jump_or;
      @(posedge REF_CLK);
      PAGE_LATCH <= 7'h58;
      issue(OPC_JUMP | 14'h07FF, 8'h00);
      chk({PC_LOAD, PC}, 16'hDFFF);
      issue(OPC_CLEAR_ACC, 8'h00);
      chk({NOP_CYCLE, ACC}, 9'h142);
      issue(OPC_OR_FILE | 14'h0081, 8'h30);
      chk({FILE_WE, FILE_WDATA}, 9'h172);
      issue(OPC_OR_FILE | 14'h0001, 8'h00);
      chk({NULL_FLAG, ACC}, 9'h042);
   endtask
   // a mid-run reset must drop a pending flush, so the next word runs
   task t_reset;
      issue(OPC_ADD_SKIP, 8'hFF);
      @(posedge REF_CLK);
      RESET_N <= 1'b0;
      repeat (2) @(posedge REF_CLK);
      #1;
      chk({NOP_CYCLE, PC_LOAD, FILE_WE, NULL_FLAG, ACC}, 12'h000);
      chk(PC, 15'h0000);
      @(posedge REF_CLK);
      RESET_N <= 1'b1;
      issue(OPC_OR_LIT | 14'h0021, 8'h00);
      chk({NOP_CYCLE, ACC}, 9'h021);
   endtask
   initial begin
      repeat (4) @(posedge REF_CLK);
      RESET_N <= 1'b1;
      t_or_clear();
      t_sub_skip();
      t_add();
      t_jump_or();
      t_reset();
      close_out();
   end
endmodule // cise_core_tb
bind cise_core cise_core_asserts i_chk (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
   .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .FILE_RDATA(FILE_RDATA), .PAGE_LATCH(PAGE_LATCH),
   .FILE_WDATA(FILE_WDATA), .FILE_WE(FILE_WE), .ACC(ACC), .NULL_FLAG(NULL_FLAG), .PC(PC),
   .PC_LOAD(PC_LOAD), .NOP_CYCLE(NOP_CYCLE));
`default_nettype wire
